// file: design/pcd_pkg.sv
// Package of the packet command decoder: opcodes, field positions,
// fixed checks and the carriers shared by the decoder and its parser.
// Assumes one 100 MHz clock and a 12-byte command packet.
package pcd_pkg;

    localparam int PCD_PKT_BYTES = 12;

    // Task-file command codes
    localparam logic [7:0] PCD_TF_STBY_A   = 8'h94;
    localparam logic [7:0] PCD_TF_STBY_B   = 8'he0;

    // Packet operation codes
    localparam logic [7:0] PCD_OP_ERASE    = 8'h2c;
    localparam logic [7:0] PCD_OP_FORMAT   = 8'h04;
    localparam logic [7:0] PCD_OP_INQUIRY  = 8'h12;
    localparam logic [7:0] PCD_OP_MSEL     = 8'h55;
    localparam logic [7:0] PCD_OP_MSENSE   = 8'h5a;
    localparam logic [7:0] PCD_OP_PREVENT  = 8'h1e;
    localparam logic [7:0] PCD_OP_READ10   = 8'h28;
    localparam logic [7:0] PCD_OP_READ12   = 8'ha8;
    localparam logic [7:0] PCD_OP_RDCAP    = 8'h25;
    localparam logic [7:0] PCD_OP_RDFMTCAP = 8'h23;
    localparam logic [7:0] PCD_OP_RDDEFECT = 8'h37;
    localparam logic [7:0] PCD_OP_RDLONG   = 8'h3e;
    localparam logic [7:0] PCD_OP_RCVDIAG  = 8'h1c;
    localparam logic [7:0] PCD_OP_REQSENSE = 8'h03;
    localparam logic [7:0] PCD_OP_SNDDIAG  = 8'h1d;
    localparam logic [7:0] PCD_OP_SEEK10   = 8'h2b;
    localparam logic [7:0] PCD_OP_STARTSTP = 8'h1b;
    localparam logic [7:0] PCD_OP_SYNCCACH = 8'h35;
    localparam logic [7:0] PCD_OP_TUR      = 8'h00;
    localparam logic [7:0] PCD_OP_VERIFY   = 8'h2f;
    localparam logic [7:0] PCD_OP_WRITE10  = 8'h2a;
    localparam logic [7:0] PCD_OP_WRITE12  = 8'haa;
    localparam logic [7:0] PCD_OP_WRVERIFY = 8'h2e;
    localparam logic [7:0] PCD_OP_WRBUF    = 8'h3b;
    localparam logic [7:0] PCD_OP_WRLONG   = 8'h3f;

    // Field positions in the command packet
    localparam int PCD_LUN_MSB      = 7;
    localparam int PCD_LUN_LSB      = 5;
    localparam int PCD_FORMAT_PARAMS_PRESENT_BIT  = 4;
    localparam int PCD_COMPLETE_LIST_FLAG_BIT  = 3;
    localparam int PCD_DLF_MSB      = 2;
    localparam int PCD_ALLOC_BYTE   = 4;

    // Fields of the format parameter list header
    localparam int PCD_SKIP_CERTIFICATION_BIT     = 5;
    localparam int PCD_EARLY_COMPLETION_BIT    = 1;

    // Fixed values checked by the format path, and the parameter list size
    localparam logic [2:0]  PCD_DLF_ONLY     = 3'h7;
    localparam logic [15:0] PCD_DEFLIST_LEN  = 16'h0008;
    localparam int          PCD_PARAM_BYTES  = 12;

    // Parsed packet carrier
    typedef struct packed {
        logic [7:0]  opcode;
        logic [2:0]  logical_unit_field;
        logic [31:0] lba;
        logic [15:0] xfer_len;
        logic        format_params_present;
        logic        complete_list_flag;
        logic [2:0]  defect_list_format;
        logic [7:0]  alloc_len;
    } pcd_pkt_s;

    // Parsed format parameter list carrier
    typedef struct packed {
        logic        skip_certification;
        logic        early_completion;
        logic [15:0] defect_list_len;
        logic [31:0] num_blocks;
        logic [23:0] block_len;
    } pcd_fmt_s;

    typedef enum logic [2:0] {
        PCD_IDLE  = 3'b000,
        PCD_PARAM = 3'b001,
        PCD_WORK  = 3'b011,
        PCD_DONE  = 3'b010,
        PCD_FMTBG = 3'b110
    } pcd_state_e;

    typedef enum logic [1:0] {
        PCD_ST_GOOD    = 2'h0,
        PCD_ST_CHECK   = 2'h1,
        PCD_ST_ABORTED = 2'h2
    } pcd_status_e;

endpackage : pcd_pkg

// file: design/pcd_field_parse.sv
// Field extractor: splits the command packet and parameter list bytes
// into the carriers. Inputs are flat byte vectors, byte 0 in bits 7:0.
`timescale 1ns/100ps
module pcd_field_parse
    import pcd_pkg::*;
(
    // Raw bytes
    input  wire logic [8*PCD_PKT_BYTES-1:0]   pkt_bytes,
    input  wire logic [8*PCD_PARAM_BYTES-1:0] param_bytes,
    // Parsed fields
    output pcd_pkt_s                          pkt,
    output pcd_fmt_s                          fmt
);
    function automatic logic [7:0] pb(input int i);
        pb = pkt_bytes[8*i +: 8];
    endfunction : pb

    function automatic logic [7:0] qb(input int i);
        qb = param_bytes[8*i +: 8];
    endfunction : qb

    always_comb begin
        pkt.opcode                = pb(0);
        pkt.logical_unit_field    = pkt_bytes[8+PCD_LUN_MSB:8+PCD_LUN_LSB];
        pkt.lba                   = {pb(2), pb(3), pb(4), pb(5)};
        pkt.xfer_len              = {pb(7), pb(8)};
        pkt.format_params_present = pkt_bytes[8+PCD_FORMAT_PARAMS_PRESENT_BIT];
        pkt.complete_list_flag    = pkt_bytes[8+PCD_COMPLETE_LIST_FLAG_BIT];
        pkt.defect_list_format    = pkt_bytes[8+PCD_DLF_MSB:8];
        pkt.alloc_len             = pb(PCD_ALLOC_BYTE);
        // Interleave in bytes 3-4 is never extracted
        fmt.skip_certification    = param_bytes[8+PCD_SKIP_CERTIFICATION_BIT];
        fmt.early_completion      = param_bytes[8+PCD_EARLY_COMPLETION_BIT];
        fmt.defect_list_len       = {qb(2), qb(3)};
        fmt.num_blocks            = {qb(4), qb(5), qb(6), qb(7)};
        fmt.block_len             = {qb(9), qb(10), qb(11)};
    end

endmodule : pcd_field_parse

// file: design/pcd_decoder.sv
// Packet command decoder: validates task-file and packet commands,
// steers erase, format and inquiry jobs, and reports status.
// Assumes the host adapter presents whole packets and parameter lists
// with one-cycle strobes, and the media engine answers with done pulses.
`timescale 1ns/100ps
module pcd_decoder
    import pcd_pkg::*;
#(
    parameter int          INQ_LEN  = 36,
    parameter logic [31:0] CAP_BLKS = 32'h0000_1000,
    parameter logic [23:0] CAP_BLEN = 24'h000800
)(
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          rst_b,
    // Task-file command
    input  wire logic                          tf_cmd_valid,
    input  wire logic [7:0]                    tf_cmd_code,
    // Packet and parameter list
    input  wire logic                          pkt_valid,
    input  wire logic [8*PCD_PKT_BYTES-1:0]    pkt_bytes,
    input  wire logic                          param_valid,
    input  wire logic [8*PCD_PARAM_BYTES-1:0]  param_bytes,
    // Unit attention
    input  wire logic                          unit_attn_set,
    input  wire logic                          unit_attn_clr,
    // Media engine
    input  wire logic                          media_done,
    // Outputs to host side
    output logic                               cmd_done,
    output pcd_status_e                        cmd_status,
    output logic                               param_req,
    output logic                               status_ready,
    output logic                               standby,
    output logic                               unit_attn,
    // Outputs to media engine
    output logic                               erase_start,
    output logic [31:0]                        erase_lba,
    output logic [15:0]                        erase_count,
    output logic                               format_start,
    output logic                               format_certify,
    output logic                               inq_start,
    output logic [7:0]                         inq_bytes
);
    ////////////////////////////////////////////////////////////////////
    pcd_pkt_s   pkt;
    pcd_fmt_s   fmt;

    pcd_field_parse u_parse (
        .pkt_bytes   (pkt_bytes),
        .param_bytes (param_bytes),
        .pkt         (pkt),
        .fmt         (fmt)
    );

    function automatic logic op_known(input logic [7:0] op);
        case (op)
            PCD_OP_ERASE, PCD_OP_FORMAT, PCD_OP_INQUIRY, PCD_OP_MSEL,
            PCD_OP_MSENSE, PCD_OP_PREVENT, PCD_OP_READ10, PCD_OP_READ12,
            PCD_OP_RDCAP, PCD_OP_RDFMTCAP, PCD_OP_RDDEFECT, PCD_OP_RDLONG,
            PCD_OP_RCVDIAG, PCD_OP_REQSENSE, PCD_OP_SNDDIAG, PCD_OP_SEEK10,
            PCD_OP_STARTSTP, PCD_OP_SYNCCACH, PCD_OP_TUR, PCD_OP_VERIFY,
            PCD_OP_WRITE10, PCD_OP_WRITE12, PCD_OP_WRVERIFY, PCD_OP_WRBUF,
            PCD_OP_WRLONG: op_known = 1'b1;
            default:       op_known = 1'b0;
        endcase
    endfunction : op_known

    ////////////////////////////////////////////////////////////////////
    pcd_state_e   state_r,  state_nxt;
    pcd_status_e  status_r, status_nxt;
    logic         done_r,   done_nxt;
    logic         preq_r,   preq_nxt;
    logic         ready_r,  ready_nxt;
    logic         stby_r,   stby_nxt;
    logic         ua_r,     ua_nxt;
    logic         es_r,     es_nxt;
    logic [31:0]  elba_r,   elba_nxt;
    logic [15:0]  ecnt_r,   ecnt_nxt;
    logic         fs_r,     fs_nxt;
    logic         fcert_r,  fcert_nxt;
    logic         is_r,     is_nxt;
    logic [7:0]   ib_r,     ib_nxt;
    logic         imm_r,    imm_nxt;
    logic [7:0]   inq_len8;

    assign inq_len8 = 8'(INQ_LEN);

    always_comb begin
        state_nxt  = state_r;
        status_nxt = status_r;
        done_nxt   = 1'b0;
        preq_nxt   = 1'b0;
        ready_nxt  = ready_r;
        stby_nxt   = stby_r;
        es_nxt     = 1'b0;
        elba_nxt   = elba_r;
        ecnt_nxt   = ecnt_r;
        fs_nxt     = 1'b0;
        fcert_nxt  = fcert_r;
        is_nxt     = 1'b0;
        ib_nxt     = ib_r;
        imm_nxt    = imm_r;
        // Set wins over clear; inquiry never clears it
        ua_nxt     = unit_attn_set | (ua_r & ~unit_attn_clr);
        case (state_r)
            PCD_IDLE: begin
                if (tf_cmd_valid) begin
                    done_nxt = 1'b1;
                    if (tf_cmd_code == PCD_TF_STBY_A ||
                        tf_cmd_code == PCD_TF_STBY_B) begin
                        stby_nxt   = 1'b1;
                        status_nxt = PCD_ST_GOOD;
                    end else begin
                        status_nxt = PCD_ST_ABORTED;
                    end
                end else if (pkt_valid) begin
                    stby_nxt = 1'b0;
                    if (!op_known(pkt.opcode)) begin
                        done_nxt   = 1'b1;
                        status_nxt = PCD_ST_CHECK;
                    end else if (pkt.logical_unit_field != 3'h0) begin
                        done_nxt   = 1'b1;
                        status_nxt = PCD_ST_CHECK;
                    end else if (pkt.opcode == PCD_OP_ERASE) begin
                        status_nxt = PCD_ST_GOOD;
                        if (pkt.xfer_len == 16'h0000) begin
                            done_nxt = 1'b1;
                        end else begin
                            es_nxt    = 1'b1;
                            elba_nxt  = pkt.lba;
                            ecnt_nxt  = pkt.xfer_len;
                            state_nxt = PCD_WORK;
                        end
                    end else if (pkt.opcode == PCD_OP_FORMAT) begin
                        if (pkt.complete_list_flag) begin
                            done_nxt   = 1'b1;
                            status_nxt = PCD_ST_CHECK;
                        end else if (pkt.format_params_present) begin
                            if (pkt.defect_list_format != PCD_DLF_ONLY) begin
                                done_nxt   = 1'b1;
                                status_nxt = PCD_ST_CHECK;
                            end else begin
                                preq_nxt  = 1'b1;
                                state_nxt = PCD_PARAM;
                            end
                        end else begin
                            // Defaults, no list, interleave unused
                            fs_nxt     = 1'b1;
                            fcert_nxt  = 1'b1;
                            imm_nxt    = 1'b0;
                            status_nxt = PCD_ST_GOOD;
                            ready_nxt  = 1'b0;
                            state_nxt  = PCD_WORK;
                        end
                    end else if (pkt.opcode == PCD_OP_INQUIRY) begin
                        is_nxt     = 1'b1;
                        ib_nxt     = (pkt.alloc_len < inq_len8) ?
                                     pkt.alloc_len : inq_len8;
                        status_nxt = PCD_ST_GOOD;
                        state_nxt  = PCD_WORK;
                    end else begin
                        // Other listed commands handled elsewhere
                        done_nxt   = 1'b1;
                        status_nxt = PCD_ST_GOOD;
                    end
                end
            end
            PCD_PARAM: begin
                preq_nxt = ~param_valid;
                if (param_valid) begin
                    if (fmt.defect_list_len != PCD_DEFLIST_LEN) begin
                        done_nxt   = 1'b1;
                        status_nxt = PCD_ST_CHECK;
                        state_nxt  = PCD_IDLE;
                    end else if (fmt.num_blocks != CAP_BLKS ||
                                 fmt.block_len != CAP_BLEN) begin
                        done_nxt   = 1'b1;
                        status_nxt = PCD_ST_CHECK;
                        state_nxt  = PCD_IDLE;
                    end else begin
                        fs_nxt     = 1'b1;
                        fcert_nxt  = ~fmt.skip_certification;
                        imm_nxt    = fmt.early_completion;
                        status_nxt = PCD_ST_GOOD;
                        ready_nxt  = 1'b0;
                        if (fmt.early_completion) begin
                            done_nxt  = 1'b1;
                            state_nxt = PCD_FMTBG;
                        end else begin
                            state_nxt = PCD_WORK;
                        end
                    end
                end
            end
            PCD_WORK: begin
                if (media_done) begin
                    done_nxt  = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = PCD_DONE;
                end
            end
            PCD_FMTBG: begin
                if (media_done) begin
                    ready_nxt = 1'b1;
                    state_nxt = PCD_DONE;
                end
            end
            PCD_DONE: begin
                state_nxt = PCD_IDLE;
            end
            default: begin
                state_nxt = PCD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r  <= PCD_IDLE;
            status_r <= PCD_ST_GOOD;
            done_r   <= 1'b0;
            preq_r   <= 1'b0;
            ready_r  <= 1'b1;
            stby_r   <= 1'b0;
            ua_r     <= 1'b0;
            es_r     <= 1'b0;
            elba_r   <= 32'h0000_0000;
            ecnt_r   <= 16'h0000;
            fs_r     <= 1'b0;
            fcert_r  <= 1'b1;
            is_r     <= 1'b0;
            ib_r     <= 8'h00;
            imm_r    <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            status_r <= status_nxt;
            done_r   <= done_nxt;
            preq_r   <= preq_nxt;
            ready_r  <= ready_nxt;
            stby_r   <= stby_nxt;
            ua_r     <= ua_nxt;
            es_r     <= es_nxt;
            elba_r   <= elba_nxt;
            ecnt_r   <= ecnt_nxt;
            fs_r     <= fs_nxt;
            fcert_r  <= fcert_nxt;
            is_r     <= is_nxt;
            ib_r     <= ib_nxt;
            imm_r    <= imm_nxt;
        end
    end

    assign cmd_done       = done_r;
    assign cmd_status     = status_r;
    assign param_req      = preq_r;
    assign status_ready   = ready_r;
    assign standby        = stby_r;
    assign unit_attn      = ua_r;
    assign erase_start    = es_r;
    assign erase_lba      = elba_r;
    assign erase_count    = ecnt_r;
    assign format_start   = fs_r;
    assign format_certify = fcert_r;
    assign inq_start      = is_r;
    assign inq_bytes      = ib_r;

    ////////////////////////////////////////////////////////////////////
    sequence s_stby_cmd;
        tf_cmd_valid && state_r == PCD_IDLE &&
        (tf_cmd_code == PCD_TF_STBY_A || tf_cmd_code == PCD_TF_STBY_B);
    endsequence

    a_standby_entry: assert property (
        @(posedge mclk) disable iff (!rst_b)
        s_stby_cmd |=> standby && cmd_done && cmd_status == PCD_ST_GOOD)
        else $error("standby not entered");

    a_tf_abort: assert property (
        @(posedge mclk) disable iff (!rst_b)
        tf_cmd_valid && state_r == PCD_IDLE && !(tf_cmd_code ==
        PCD_TF_STBY_A || tf_cmd_code == PCD_TF_STBY_B)
        |=> cmd_done && cmd_status == PCD_ST_ABORTED)
        else $error("task-file command not aborted");

    a_bad_opcode: assert property (
        @(posedge mclk) disable iff (!rst_b)
        pkt_valid && !tf_cmd_valid && state_r == PCD_IDLE &&
        !op_known(pkt.opcode)
        |=> cmd_done && cmd_status == PCD_ST_CHECK && !erase_start)
        else $error("unknown opcode not checked");

    a_lun_check: assert property (
        @(posedge mclk) disable iff (!rst_b)
        pkt_valid && !tf_cmd_valid && state_r == PCD_IDLE &&
        pkt.logical_unit_field != 3'h0
        |=> cmd_done && cmd_status == PCD_ST_CHECK)
        else $error("nonzero unit not checked");

    a_erase_fields: assert property (
        @(posedge mclk) disable iff (!rst_b)
        erase_start |-> erase_count == $past(pkt.xfer_len) &&
        erase_lba == $past(pkt.lba) && erase_count != 16'h0000)
        else $error("erase fields wrong");

    a_erase_zero: assert property (
        @(posedge mclk) disable iff (!rst_b)
        pkt_valid && !tf_cmd_valid && state_r == PCD_IDLE &&
        pkt.opcode == PCD_OP_ERASE && pkt.logical_unit_field == 3'h0 &&
        pkt.xfer_len == 16'h0000
        |=> cmd_done && !erase_start && cmd_status == PCD_ST_GOOD)
        else $error("zero erase mishandled");

    a_complete_list_flag_chk: assert property (
        @(posedge mclk) disable iff (!rst_b)
        pkt_valid && !tf_cmd_valid && state_r == PCD_IDLE &&
        pkt.opcode == PCD_OP_FORMAT && pkt.logical_unit_field == 3'h0 &&
        pkt.complete_list_flag
        |=> cmd_done && cmd_status == PCD_ST_CHECK && !format_start)
        else $error("complete list not checked");

    a_deflen_chk: assert property (
        @(posedge mclk) disable iff (!rst_b)
        state_r == PCD_PARAM && param_valid &&
        fmt.defect_list_len != PCD_DEFLIST_LEN
        |=> cmd_done && cmd_status == PCD_ST_CHECK && state_r == PCD_IDLE)
        else $error("defect list length not checked");

    a_early_ready: assert property (
        @(posedge mclk) disable iff (!rst_b)
        state_r == PCD_FMTBG |-> !status_ready)
        else $error("ready high during format");

    a_inq_limit: assert property (
        @(posedge mclk) disable iff (!rst_b)
        inq_start |-> inq_bytes <= $past(pkt.alloc_len) &&
        inq_bytes <= inq_len8 &&
        (inq_bytes == $past(pkt.alloc_len) || inq_bytes == inq_len8))
        else $error("inquiry exceeds allocation");

    a_ua_kept: assert property (
        @(posedge mclk) disable iff (!rst_b)
        inq_start && unit_attn && !unit_attn_clr |=> unit_attn)
        else $error("unit attention lost on inquiry");

endmodule : pcd_decoder

// file: verif/pcd_media_model.sv
// Media engine model: answers every job start with one done pulse.
// Assumes one start pulse per job and a latency chosen by the bench.
`timescale 1ns/100ps
module pcd_media_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Job handshake
    input  wire logic       job_start,
    input  wire logic [3:0] lat,
    output logic            media_done
);
    logic [4:0] cnt_r;
    always_ff @(posedge mclk) begin
        if (!rst_b || job_start) begin
            cnt_r <= job_start ? {1'b0, lat} + 5'h1 : 5'h0;
        end else if (cnt_r != 5'h0) begin
            cnt_r <= cnt_r - 5'h1;
        end
    end
    assign media_done = (cnt_r == 5'h1);
endmodule : pcd_media_model

// file: verif/packet_command_decoder_tb_top.sv
// Bench of the packet command decoder: drives commands, checks results.
// Assumes the media model answers each job start.
`timescale 1ns/100ps
module packet_command_decoder_tb_top;
    import pcd_pkg::*;
    localparam int          INQ  = 36;
    localparam logic [31:0] BLKS = 32'h0000_1000;
    localparam logic [23:0] BLEN = 24'h000800;
    logic        mclk, rst_b, tf_v, pk_v, pr_v, ua_set, ua_clr, cmd_done;
    logic        param_req, status_ready, standby, unit_attn, media_done;
    logic        erase_start, format_start, format_certify, inq_start;
    logic [3:0]  lat;
    logic [7:0]  tf_code, inq_bytes;
    logic [15:0] erase_count;
    logic [31:0] erase_lba, seed;
    logic [95:0] pkt, prm;
    pcd_status_e cmd_status;
    pcd_status_e qs[$];
    logic [47:0] qe[$];
    logic [7:0]  qi[$];
    logic        qf[$];
    int          error_cnt, n_tests;
    pcd_decoder dut (.mclk(mclk), .rst_b(rst_b), .tf_cmd_valid(tf_v),
        .tf_cmd_code(tf_code), .pkt_valid(pk_v), .pkt_bytes(pkt),
        .param_valid(pr_v), .param_bytes(prm), .unit_attn_set(ua_set),
        .unit_attn_clr(ua_clr), .media_done(media_done),
        .cmd_done(cmd_done), .cmd_status(cmd_status),
        .param_req(param_req), .status_ready(status_ready),
        .standby(standby), .unit_attn(unit_attn),
        .erase_start(erase_start), .erase_lba(erase_lba),
        .erase_count(erase_count), .format_start(format_start),
        .format_certify(format_certify), .inq_start(inq_start),
        .inq_bytes(inq_bytes));
    pcd_media_model media (.mclk(mclk), .rst_b(rst_b), .lat(lat),
        .job_start(erase_start | format_start | inq_start),
        .media_done(media_done));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [95:0] pk(input logic [7:0] op, b1,
                                       input logic [31:0] a,
                                       input logic [15:0] n);
        pk = '0;
        pk[15:0] = {b1, op};
        pk[47:16] = {<<8{a}};
        pk[71:56] = {<<8{n}};
    endfunction : pk
    function automatic logic [95:0] fl(input logic [7:0] b1,
                                       input logic [15:0] len,
                                       input logic [31:0] nb,
                                       input logic [23:0] bl);
        fl = '0;
        fl[15:8] = b1;
        fl[31:16] = {<<8{len}};
        fl[63:32] = {<<8{nb}};
        fl[95:72] = {<<8{bl}};
    endfunction : fl
    task automatic conclude();
        $display("Comparisons %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic cmp_status(input pcd_status_e e, g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("Error cmd_status exp %0d got %0d", e, g);
        end
    endtask : cmp_status
    task automatic cmp_val(input string nm, input logic [47:0] e, g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s exp %0h got %0h", nm, e, g);
        end
    endtask : cmp_val
    // Sends one command, feeds the list on request, waits for the end
    task automatic run(input logic tf, input logic [95:0] p, q,
                       input pcd_status_e st, output logic sr);
        int i;
        qs.push_back(st);
        @(posedge mclk);
        {tf_v, pk_v, tf_code, pkt, prm} <= {tf, !tf, p[7:0], p, q};
        lat <= 4'(rnd() % 9);
        @(posedge mclk);
        {tf_v, pk_v} <= 2'b00;
        for (i = 0; i < 400; i++) begin
            @(posedge mclk);
            pr_v <= (param_req === 1'b1) && !pr_v;
            if (cmd_done === 1'b1) break;
        end
        sr = status_ready;
        for (; i < 400 && status_ready !== 1'b1; i++) @(posedge mclk);
        if (i >= 400) begin
            error_cnt++;
            conclude();
        end
        repeat (2) @(posedge mclk);
    endtask : run
    ////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        if (cmd_done === 1'b1) begin
            if (qs.size() == 0) cmp_val("cmd_done", 0, 1);
            else cmp_status(qs.pop_front(), cmd_status);
        end
        if (erase_start === 1'b1) begin
            if (qe.size() == 0) cmp_val("erase_start", 0, 1);
            else cmp_val("erase", qe.pop_front(), {erase_lba, erase_count});
        end
        if (format_start === 1'b1) begin
            if (qf.size() == 0) cmp_val("format_start", 0, 1);
            else cmp_val("format_certify", qf.pop_front(), format_certify);
        end
        if (inq_start === 1'b1) begin
            if (qi.size() == 0) cmp_val("inq_start", 0, 1);
            else cmp_val("inq_bytes", qi.pop_front(), inq_bytes);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        static logic [7:0] ops[22] = '{8'h55, 8'h5a, 8'h1e, 8'h28, 8'ha8,
            8'h25,
            8'h23, 8'h37, 8'h3e, 8'h1c, 8'h03, 8'h1d, 8'h2b, 8'h1b, 8'h35,
            8'h00, 8'h2f, 8'h2a, 8'haa, 8'h2e, 8'h3b, 8'h3f};
        logic [31:0] a;
        logic [15:0] n;
        logic        sr;
        {tf_v, pk_v, pr_v, ua_set, ua_clr, rst_b} = '0;
        {tf_code, pkt, prm, lat} = '0;
        {seed, error_cnt, n_tests} = {32'h8677, 64'h0};
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (ops[k]) begin
            run(1'b1, pk(k[0] ? 8'h94 : 8'he0, 0, 0, 0), 0, PCD_ST_GOOD, sr);
            cmp_val("standby", 1, standby);
            run(0, pk(ops[k], 0, rnd(), 16'(rnd())), 0, PCD_ST_GOOD, sr);
            cmp_val("standby", 0, standby);
        end
        run(1'b1, pk(8'ha2, 0, 0, 0), 0, PCD_ST_ABORTED, sr);
        run(0, pk(8'hff, 0, 0, 0), 0, PCD_ST_CHECK, sr);
        run(0, pk(8'h00, {3'(rnd() % 7 + 1), 5'h0}, 0, 0), 0, PCD_ST_CHECK, sr);
        repeat (2) begin
            a = rnd();
            n = 16'(rnd()) | 16'h1;
            qe.push_back({a, n});
            run(0, pk(8'h2c, 0, a, n), 0, PCD_ST_GOOD, sr);
        end
        run(0, pk(8'h2c, 0, rnd(), 0), 0, PCD_ST_GOOD, sr);
        qf.push_back(1'b1);
        run(0, pk(8'h04, 0, rnd(), 0), 0, PCD_ST_GOOD, sr);
        qf.push_back(1'b0);
        run(0, pk(8'h04, 8'h17, rnd(), 0), fl(8'h22, 8, BLKS, BLEN), PCD_ST_GOOD, sr);
        cmp_val("status_ready", 0, sr);
        qf.push_back(1'b1);
        run(0, pk(8'h04, 8'h17, 0, 0), fl(0, 8, BLKS, BLEN),
            PCD_ST_GOOD, sr);
        cmp_val("status_ready", 1, sr);
        run(0, pk(8'h04, 8'h08, 0, 0), 0, PCD_ST_CHECK, sr);
        run(0, pk(8'h04, 8'h15, 0, 0), fl(0, 8, BLKS, BLEN), PCD_ST_CHECK, sr);
        run(0, pk(8'h04, 8'h17, 0, 0), fl(0, 7, BLKS, BLEN), PCD_ST_CHECK, sr);
        run(0, pk(8'h04, 8'h17, 0, 0), fl(0, 8, BLKS + 1, BLEN), PCD_ST_CHECK, sr);
        run(0, pk(8'h04, 8'h17, 0, 0), fl(0, 8, BLKS, BLEN - 1), PCD_ST_CHECK, sr);
        ua_set <= 1'b1;
        @(posedge mclk);
        ua_set <= 1'b0;
        qi.push_back(8'd20);
        run(0, pk(8'h12, 0, 32'h1400, 0), 0, PCD_ST_GOOD, sr);
        qi.push_back(8'(INQ));
        run(0, pk(8'h12, 0, 32'hc800, 0), 0, PCD_ST_GOOD, sr);
        cmp_val("unit_attn", 1, unit_attn);
        ua_clr <= 1'b1;
        @(posedge mclk);
        ua_clr <= 1'b0;
        repeat (2) @(posedge mclk);
        cmp_val("unit_attn", 0, unit_attn);
        conclude();
    end
endmodule : packet_command_decoder_tb_top
